// ===== core/snv_pkg.sv
// package: constants, phases and state records for the serial non-volatile memory slave
package snv_pkg;

    // array geometry
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 16384;
    localparam int ID_W = 32;

    // field lengths in serial clocks
    localparam int OPC_BITS = 8;
    localparam int ADDR_BITS = 16;
    localparam int DUMMY_BITS = 8;
    localparam int BYTE_BITS = 8;

    // opcodes
    localparam logic [7:0] OPC_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OPC_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;
    localparam logic [7:0] OPC_READ_IDENTIFIER = 8'h9F;
    localparam logic [7:0] OPC_FAST_READ = 8'h0B;
    localparam logic [7:0] OPC_SLEEP = 8'hB9;

    // identification code; this value is arbitrary
    localparam logic [31:0] ID_CODE = 32'h5A3C_0100;

    // sleep exit timing
    localparam int SLEEP_WAKE_TIME_NS = 1000;
    localparam int CLK_SYS_PERIOD_NS = 100;
    localparam int SLEEP_WAKE_RAW = SLEEP_WAKE_TIME_NS / CLK_SYS_PERIOD_NS;
    localparam int SLEEP_WAKE_CYCLES = (SLEEP_WAKE_RAW < 1) ? 1 : SLEEP_WAKE_RAW;
    // cycles spent in the chip-select synchroniser and edge detector
    localparam int CS_SYNC_CYCLES = 4;
    localparam int WAKE_COUNT_RAW = SLEEP_WAKE_CYCLES - CS_SYNC_CYCLES;
    localparam int WAKE_COUNT = (WAKE_COUNT_RAW < 1) ? 1 : WAKE_COUNT_RAW;
    localparam int WAKE_CNT_W = 4;

    // reset values
    localparam logic [4:0] CNT_RESET = 5'h00;
    localparam logic [15:0] SHREG_RESET = 16'h0000;
    localparam logic [13:0] ADDR_RESET = 14'h0000;
    localparam logic [31:0] TX_RESET = 32'h0000_0000;
    localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_RESET = 4'h0;

    typedef enum logic [5:0] {
        PH_OPCODE = 6'h01,
        PH_ADDRESS = 6'h02,
        PH_DUMMY = 6'h04,
        PH_READ_DATA = 6'h08,
        PH_WRITE_DATA = 6'h10,
        PH_IDENT = 6'h20
    } snv_phase_t;

    // serial-clock rising-edge state
    typedef struct packed {
        logic done;
        snv_phase_t phase;
        logic [4:0] cnt;
        logic [7:0] opcode;
        logic [15:0] shreg;
        logic [13:0] addr;
        logic [31:0] tx;
        logic wel;
        logic armed;
        logic rst_s1;
        logic rst_s2;
    } snv_lnk_t;

    // serial-clock falling-edge state, drives the data pin
    typedef struct packed {
        logic so;
        logic so_oe_n;
    } snv_out_t;

    localparam snv_out_t OUT_IDLE = '{so: 1'b0, so_oe_n: 1'b1};

    // system-clock state
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic cs_s4;
        logic arm_s1;
        logic arm_s2;
        logic asleep;
        logic [WAKE_CNT_W-1:0] wake_cnt;
        logic wel_s1;
        logic wel_s2;
        logic write_latch_on;
    } snv_sys_t;

endpackage : snv_pkg

// ===== core/snv_spi_nv_slave.sv
// serial-clocked slave front end and byte array of the non-volatile memory
`timescale 1ns/1ps

// Overview of operation
// - works in clock modes 0 and 3 only; idle level of the clock is irrelevant.
// - chip select high deselects, floats the data output, ignores all other inputs.
// - each command starts with eight opcode bits after chip select falls.
// - chip select rising mid-opcode discards it and runs nothing.
// - opcode 06h sets the write latch, needed before any write.
// - opcode 04h clears the write latch; writes then leave the array untouched.
// - read opcode 03h is followed by a sixteen bit address, MSB first.
// - the two top address bits are ignored; fourteen bits select the byte.
// - read data leaves on the output over eight clocks, changing on falling edges.
// - reads keep incrementing and wrapping the address until chip select rises.
// - write opcode 02h plus address; each byte is stored once eight bits arrive.
// - further write bytes go to incrementing, wrapping addresses until chip select rises.
// - identifier read 9Fh takes thirty-two more clocks with the input ignored.
// - the thirty-two bit identifier starts out on the falling edge after the eighth rising edge.
// - fast read 0Bh takes address then eight dummy clocks before data.
// - fast read streams wrapping bytes, ignoring the input, until chip select rises.
// - sleep opcode B9h sleeps at the next chip select rise unless clocked meanwhile.
// - while asleep the clock and input are ignored and the output floats, but only as long as chip select stays high.
// - sleep ends within one microsecond of chip select falling.
// - hold suspends the command, ignores clock and input, floats read output.
module snv_spi_nv_slave (
    // system side
    input wire logic clk_sys,
    input wire logic reset,
    output logic asleep,
    output logic write_latch_on,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    output logic so,
    output logic so_oe_n
);

    localparam int WAKE_BOUND = 8;

    snv_pkg::snv_lnk_t lnk;
    snv_pkg::snv_lnk_t next_lnk;
    snv_pkg::snv_out_t outq;
    snv_pkg::snv_out_t next_outq;
    snv_pkg::snv_sys_t sys;
    snv_pkg::snv_sys_t next_sys;

    logic [snv_pkg::DATA_W-1:0] mem [snv_pkg::MEM_DEPTH];
    logic in_frame;
    logic mem_we;
    logic [snv_pkg::DATA_W-1:0] mem_wdata;
    logic opc_done;
    logic [7:0] opc_val;
    logic addr_step;
    logic cs_rise;
    logic cs_fall;

    function automatic logic [13:0] inc_addr(input logic [13:0] a);
        // natural 14-bit overflow gives the wrap from the top byte to zero
        inc_addr = a + 14'h0001;
    endfunction : inc_addr

    function automatic logic [31:0] load_byte(input logic [7:0] b);
        load_byte = {b, 24'h00_0000};
    endfunction : load_byte

    // ---------------------------------------------------------------
    // link domain, rising edges: command decode, address, array access
    // ---------------------------------------------------------------

    // frame marker; chip select high clears it at once, so a partial opcode dies with it
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            in_frame <= 1'b0;
        end else if (hold_n) begin
            in_frame <= 1'b1;
        end
    end

    always_comb begin
        logic [15:0] shift_in;
        snv_pkg::snv_phase_t cur_phase;
        logic [4:0] cur_cnt;
        logic cur_done;
        shift_in = snv_pkg::SHREG_RESET;
        cur_phase = snv_pkg::PH_OPCODE;
        cur_cnt = snv_pkg::CNT_RESET;
        cur_done = 1'b0;
        next_lnk = lnk;
        mem_we = 1'b0;
        mem_wdata = 8'h00;
        opc_done = 1'b0;
        opc_val = 8'h00;
        addr_step = 1'b0;
        next_lnk.rst_s1 = reset;
        next_lnk.rst_s2 = lnk.rst_s1;
        if (lnk.rst_s2) begin
            next_lnk.done = 1'b0;
            next_lnk.phase = snv_pkg::PH_OPCODE;
            next_lnk.cnt = snv_pkg::CNT_RESET;
            next_lnk.opcode = 8'h00;
            next_lnk.shreg = snv_pkg::SHREG_RESET;
            next_lnk.addr = snv_pkg::ADDR_RESET;
            next_lnk.tx = snv_pkg::TX_RESET;
            next_lnk.wel = 1'b0;
            next_lnk.armed = 1'b0;
        end else if (hold_n && !cs_n) begin
            // clocks while deselected must not move the command state: a stray edge
            // after the sleep frame would otherwise cancel a sleep that was already due
            // the first edge of a frame starts from a clean opcode phase
            if (in_frame) begin
                cur_phase = lnk.phase;
                cur_cnt = lnk.cnt;
                cur_done = lnk.done;
                shift_in = {lnk.shreg[14:0], si};
            end else begin
                shift_in = {15'h0000, si};
            end
            // any clock after the sleep opcode cancels the pending sleep
            next_lnk.armed = 1'b0;
            next_lnk.shreg = shift_in;
            next_lnk.phase = cur_phase;
            next_lnk.done = cur_done;
            next_lnk.cnt = cur_cnt + 5'h01;
            if (cur_done) begin
                next_lnk.cnt = cur_cnt;
            end else begin
                unique case (cur_phase)
                    snv_pkg::PH_OPCODE: begin
                        if (cur_cnt == 5'(snv_pkg::OPC_BITS - 1)) begin
                            opc_done = 1'b1;
                            opc_val = shift_in[7:0];
                            next_lnk.opcode = shift_in[7:0];
                            next_lnk.cnt = snv_pkg::CNT_RESET;
                            next_lnk.done = 1'b1;
                            case (shift_in[7:0])
                                snv_pkg::OPC_SET_WRITE_LATCH: begin
                                    next_lnk.wel = 1'b1;
                                end
                                snv_pkg::OPC_CLEAR_WRITE_LATCH: begin
                                    next_lnk.wel = 1'b0;
                                end
                                snv_pkg::OPC_READ, snv_pkg::OPC_WRITE,
                                snv_pkg::OPC_FAST_READ: begin
                                    next_lnk.done = 1'b0;
                                    next_lnk.phase = snv_pkg::PH_ADDRESS;
                                end
                                snv_pkg::OPC_READ_IDENTIFIER: begin
                                    next_lnk.done = 1'b0;
                                    next_lnk.phase = snv_pkg::PH_IDENT;
                                    next_lnk.tx = snv_pkg::ID_CODE;
                                end
                                snv_pkg::OPC_SLEEP: begin
                                    next_lnk.armed = 1'b1;
                                end
                                default: begin
                                    // undefined codes are dropped; the rest of the frame idles
                                    next_lnk.done = 1'b1;
                                end
                            endcase
                        end
                    end
                    snv_pkg::PH_ADDRESS: begin
                        if (cur_cnt == 5'(snv_pkg::ADDR_BITS - 1)) begin
                            next_lnk.cnt = snv_pkg::CNT_RESET;
                            // top two address bits fall away here
                            next_lnk.addr = shift_in[13:0];
                            if (lnk.opcode == snv_pkg::OPC_READ) begin
                                next_lnk.phase = snv_pkg::PH_READ_DATA;
                                next_lnk.tx = load_byte(mem[shift_in[13:0]]);
                                next_lnk.addr = inc_addr(shift_in[13:0]);
                            end else if (lnk.opcode == snv_pkg::OPC_FAST_READ) begin
                                next_lnk.phase = snv_pkg::PH_DUMMY;
                            end else begin
                                next_lnk.phase = snv_pkg::PH_WRITE_DATA;
                            end
                        end
                    end
                    snv_pkg::PH_DUMMY: begin
                        // dummy bits are shifted in but never used
                        if (cur_cnt == 5'(snv_pkg::DUMMY_BITS - 1)) begin
                            next_lnk.cnt = snv_pkg::CNT_RESET;
                            next_lnk.phase = snv_pkg::PH_READ_DATA;
                            next_lnk.tx = load_byte(mem[lnk.addr]);
                            next_lnk.addr = inc_addr(lnk.addr);
                            addr_step = 1'b1;
                        end
                    end
                    snv_pkg::PH_READ_DATA: begin
                        // input is ignored; the byte register shifts toward the pin
                        if (cur_cnt == 5'(snv_pkg::BYTE_BITS - 1)) begin
                            next_lnk.cnt = snv_pkg::CNT_RESET;
                            next_lnk.tx = load_byte(mem[lnk.addr]);
                            next_lnk.addr = inc_addr(lnk.addr);
                            addr_step = 1'b1;
                        end else begin
                            next_lnk.tx = {lnk.tx[30:0], 1'b0};
                        end
                    end
                    snv_pkg::PH_WRITE_DATA: begin
                        if (cur_cnt == 5'(snv_pkg::BYTE_BITS - 1)) begin
                            next_lnk.cnt = snv_pkg::CNT_RESET;
                            // a clear latch turns the byte into a no-op but still advances
                            mem_we = lnk.wel;
                            mem_wdata = shift_in[7:0];
                            next_lnk.addr = inc_addr(lnk.addr);
                            addr_step = 1'b1;
                        end
                    end
                    snv_pkg::PH_IDENT: begin
                        // input ignored for the full identifier
                        if (cur_cnt == 5'(snv_pkg::ID_W - 1)) begin
                            next_lnk.done = 1'b1;
                            next_lnk.cnt = snv_pkg::CNT_RESET;
                        end else begin
                            next_lnk.tx = {lnk.tx[30:0], 1'b0};
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sck) begin
        lnk <= next_lnk;
    end

    // non-volatile array: no reset, contents survive everything
    always_ff @(posedge sck) begin
        if (mem_we) begin
            mem[lnk.addr] <= mem_wdata;
        end
    end

    // ---------------------------------------------------------------
    // link domain, falling edges: the data pin
    // ---------------------------------------------------------------

    always_comb begin
        next_outq = outq;
        // during hold the pin value is frozen; the async set below floats it
        if (hold_n) begin
            next_outq.so = lnk.tx[31];
            next_outq.so_oe_n = !(in_frame && !lnk.done &&
                ((lnk.phase == snv_pkg::PH_READ_DATA) || (lnk.phase == snv_pkg::PH_IDENT)));
        end
    end

    // deselect or hold floats the pin at once; after hold release the pin
    // returns on the next falling edge, so the master must not sample before it
    always_ff @(negedge sck or posedge cs_n or negedge hold_n) begin
        if (cs_n || !hold_n) begin
            outq <= snv_pkg::OUT_IDLE;
        end else begin
            outq <= next_outq;
        end
    end

    assign so = outq.so;
    assign so_oe_n = outq.so_oe_n;

    // ---------------------------------------------------------------
    // system domain: sleep state and status
    // ---------------------------------------------------------------

    // edges are taken from the third and fourth flops only
    assign cs_rise = sys.cs_s3 && !sys.cs_s4;
    assign cs_fall = !sys.cs_s3 && sys.cs_s4;

    always_comb begin
        next_sys = sys;
        next_sys.cs_s1 = cs_n;
        next_sys.cs_s2 = sys.cs_s1;
        next_sys.cs_s3 = sys.cs_s2;
        next_sys.cs_s4 = sys.cs_s3;
        next_sys.arm_s1 = lnk.armed;
        next_sys.arm_s2 = sys.arm_s1;
        next_sys.wel_s1 = lnk.wel;
        next_sys.wel_s2 = sys.wel_s1;
        next_sys.write_latch_on = sys.wel_s2;
        if (reset) begin
            next_sys.cs_s1 = 1'b1;
            next_sys.cs_s2 = 1'b1;
            next_sys.cs_s3 = 1'b1;
            next_sys.cs_s4 = 1'b1;
            next_sys.arm_s1 = 1'b0;
            next_sys.arm_s2 = 1'b0;
            next_sys.asleep = 1'b0;
            next_sys.wake_cnt = snv_pkg::WAKE_CNT_RESET;
            next_sys.wel_s1 = 1'b0;
            next_sys.wel_s2 = 1'b0;
            next_sys.write_latch_on = 1'b0;
        end else if (!sys.asleep) begin
            // the armed flag settled long before the delayed edge arrives
            if (cs_rise && sys.arm_s2) begin
                next_sys.asleep = 1'b1;
            end
        end else if (cs_fall || (sys.wake_cnt != snv_pkg::WAKE_CNT_RESET)) begin
            if (sys.wake_cnt == snv_pkg::WAKE_CNT_W'(snv_pkg::WAKE_COUNT - 1)) begin
                next_sys.asleep = 1'b0;
                next_sys.wake_cnt = snv_pkg::WAKE_CNT_RESET;
            end else begin
                next_sys.wake_cnt = sys.wake_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        sys <= next_sys;
    end

    assign asleep = sys.asleep;
    assign write_latch_on = sys.write_latch_on;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------

    a_latch_set_cmd: assert property (@(posedge sck) disable iff (lnk.rst_s2)
        (hold_n && opc_done && (opc_val == snv_pkg::OPC_SET_WRITE_LATCH)) |=> lnk.wel)
        else $error("write latch not set by its opcode");

    a_latch_clear_cmd: assert property (@(posedge sck) disable iff (lnk.rst_s2)
        (hold_n && opc_done && (opc_val == snv_pkg::OPC_CLEAR_WRITE_LATCH)) |=> !lnk.wel)
        else $error("write latch not cleared by its opcode");

    a_no_unlatched_write: assert property (@(posedge sck) disable iff (lnk.rst_s2)
        mem_we |-> (lnk.wel && (lnk.phase == snv_pkg::PH_WRITE_DATA)))
        else $error("array written while latch clear");

    a_addr_wrap_top: assert property (@(posedge sck) disable iff (lnk.rst_s2)
        (hold_n && addr_step && (lnk.addr == 14'h3FFF)) |=> (lnk.addr == 14'h0000))
        else $error("address failed to wrap to zero");

    a_hold_freeze_state: assert property (@(posedge sck) disable iff (lnk.rst_s2)
        (!hold_n && in_frame) |=> ($stable(lnk.phase) && $stable(lnk.cnt) &&
        $stable(lnk.addr)))
        else $error("command advanced during hold");

    a_ident_start_code: assert property (@(posedge sck) disable iff (lnk.rst_s2)
        (hold_n && opc_done && (opc_val == snv_pkg::OPC_READ_IDENTIFIER))
        |=> ((lnk.phase == snv_pkg::PH_IDENT) && (lnk.tx == snv_pkg::ID_CODE)))
        else $error("identifier not loaded after its opcode");

    a_sleep_entry_edge: assert property (@(posedge clk_sys) disable iff (reset)
        (!sys.asleep && cs_rise && sys.arm_s2) |=> sys.asleep)
        else $error("sleep not entered at deselect");

    a_sleep_exit_bound: assert property (@(posedge clk_sys) disable iff (reset)
        (sys.asleep && cs_fall) |-> ##[1:WAKE_BOUND] !sys.asleep)
        else $error("sleep exit took too long");

    a_deselect_floats: assert property (@(posedge clk_sys) disable iff (reset)
        (sys.cs_s3 && sys.cs_s4) |-> so_oe_n)
        else $error("data pin driven while deselected");

    // clocks seen while deselected leave the command state alone
    a_idle_edges_ignored: assert property (@(posedge sck) disable iff (lnk.rst_s2)
        (cs_n && !lnk.rst_s1 && !lnk.rst_s2) |=> ($stable(lnk.phase) && $stable(lnk.armed) &&
        $stable(lnk.wel)))
        else $error("state moved on a clock while deselected");

    a_dummy_pin_float: assert property (@(posedge sck) disable iff (lnk.rst_s2)
        (!cs_n && (lnk.phase == snv_pkg::PH_DUMMY)) |-> so_oe_n)
        else $error("data pin driven during dummy clocks");

    // limitation: a rising edge straight after hold release, with no falling edge, is not covered
    a_read_pin_data: assert property (@(posedge sck) disable iff (lnk.rst_s2)
        (!cs_n && hold_n && $past(hold_n) && in_frame &&
        (lnk.phase == snv_pkg::PH_READ_DATA)) |-> (!so_oe_n && (so == lnk.tx[31])))
        else $error("read bit not on the data pin");

endmodule : snv_spi_nv_slave

// ===== dv/snv_spi_master.sv
// behavioural spi master that drives the serial link of the memory slave
`timescale 1ns/1ps
module snv_spi_master (
    // link outputs
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    // link inputs
    input wire logic so,
    input wire logic so_oe_n
);
    localparam int HALF_NS = 32;
    logic mode3 = 1'b0;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // start puts sck at the idle level of the mode; pulses also moves sck outside frames
    task automatic start(input logic m3);
        mode3 = m3;
        sck = m3;
        #HALF_NS;
        cs_n = 1'b0;
        #HALF_NS;
    endtask : start
    task automatic bits(input int n, input logic [31:0] o, output logic [31:0] i);
        i = 32'h0000_0000;
        for (int k = n - 1; k >= 0; k--) begin
            sck = 1'b0;
            si = o[k];
            #HALF_NS;
            sck = 1'b1;
            i[k] = so_oe_n ? 1'bx : so;
            #HALF_NS;
        end
    endtask : bits
    task automatic stop();
        sck = mode3;
        #HALF_NS;
        // a released data line shows the inverse of its last value
        si = ~si;
        cs_n = 1'b1;
        #HALF_NS;
    endtask : stop
    task automatic hold(output logic oe_n);
        sck = 1'b0;
        #HALF_NS;
        hold_n = 1'b0;
        #HALF_NS;
        oe_n = so_oe_n;
        repeat (4) begin
            sck = 1'b1;
            si = ~si;
            #HALF_NS;
            sck = 1'b0;
            #HALF_NS;
        end
        hold_n = 1'b1;
        #HALF_NS;
    endtask : hold
    task automatic pulses(input int n);
        repeat (n) begin
            sck = 1'b1;
            #HALF_NS;
            sck = 1'b0;
            #HALF_NS;
        end
    endtask : pulses
endmodule : snv_spi_master

// ===== dv/testbench.sv
// self-checking bench for the serial non-volatile memory slave
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic asleep, write_latch_on, sck, cs_n, si, hold_n, so, so_oe_n;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h0000_0025;
    logic [7:0] mem [int];
    logic wel = 1'b0;
    logic [31:0] got;
    always #50 clk_sys = ~clk_sys;
    snv_spi_nv_slave u_snv_spi_nv_slave (.clk_sys(clk_sys), .reset(reset), .asleep(asleep),
        .write_latch_on(write_latch_on), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
        .so(so), .so_oe_n(so_oe_n));
    snv_spi_master u_m (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
        .so_oe_n(so_oe_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic wait_sys(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_sys
    task automatic cmd(input logic [7:0] op, input logic m3);
        u_m.start(m3);
        u_m.bits(8, {24'h00_0000, op}, got);
        u_m.stop();
        if (op == snv_pkg::OPC_SET_WRITE_LATCH) wel = 1'b1;
        if (op == snv_pkg::OPC_CLEAR_WRITE_LATCH) wel = 1'b0;
        wait_sys(8);
    endtask : cmd
    task automatic wr(input logic [15:0] a, input int n, input logic m3);
        logic [7:0] d;
        u_m.start(m3);
        u_m.bits(8, {24'h00_0000, snv_pkg::OPC_WRITE}, got);
        u_m.bits(16, {16'h0000, a}, got);
        for (int k = 0; k < n; k++) begin
            d = 8'(rnd());
            u_m.bits(8, {24'h00_0000, d}, got);
            if (wel) mem[(a + k) & 16'h3FFF] = d;
        end
        u_m.stop();
    endtask : wr
    task automatic rd(input logic [15:0] a, input int n, input logic fast, input logic m3,
                      input logic h);
        logic oe_n;
        u_m.start(m3);
        if (h) u_m.hold(oe_n);
        u_m.bits(8, {24'h00_0000, fast ? snv_pkg::OPC_FAST_READ : snv_pkg::OPC_READ}, got);
        u_m.bits(16, {16'h0000, a}, got);
        if (fast) u_m.bits(8, rnd(), got);
        for (int k = 0; k < n; k++) begin
            u_m.bits(8, rnd(), got);
            check({24'h00_0000, got[7:0]}, mem[(a + k) & 16'h3FFF]);
        end
        if (h) begin
            u_m.hold(oe_n);
            check(oe_n, 1'b1);
        end
        u_m.stop();
        check(so_oe_n, 1'b1);
    endtask : rd
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end
    initial begin
        fork
            u_m.pulses(4);
            wait_sys(20);
        join
        reset = 1'b0;
        // the link side sees reset through two serial-clock flops; flush them before a frame
        u_m.pulses(2);
        wait_sys(3);
        // first seven bits of the latch-set opcode, then deselect
        u_m.start(1'b0);
        u_m.bits(7, 32'h0000_0003, got);
        u_m.stop();
        // a kept partial code would complete on this frame's first bit and set the latch
        cmd(snv_pkg::OPC_CLEAR_WRITE_LATCH, 1'b0);
        check(write_latch_on, 1'b0);
        cmd(snv_pkg::OPC_SET_WRITE_LATCH, 1'b1);
        check(write_latch_on, 1'b1);
        wr(16'hFFFE, 4, 1'b1);
        rd(16'h3FFE, 4, 1'b0, 1'b0, 1'b0);
        rd(16'h7FFF, 3, 1'b1, 1'b1, 1'b0);
        cmd(snv_pkg::OPC_CLEAR_WRITE_LATCH, 1'b0);
        check(write_latch_on, 1'b0);
        wr(16'h0000, 2, 1'b0);
        // hold before the opcode and again before deselect
        rd(16'h4000, 2, 1'b0, 1'b0, 1'b1);
        u_m.start(1'b1);
        u_m.bits(8, {24'h00_0000, snv_pkg::OPC_READ_IDENTIFIER}, got);
        u_m.bits(32, rnd(), got);
        u_m.stop();
        check(got, snv_pkg::ID_CODE);
        // one clock after the sleep opcode cancels sleep entry
        u_m.start(1'b0);
        u_m.bits(8, {24'h00_0000, snv_pkg::OPC_SLEEP}, got);
        u_m.bits(1, 32'h0000_0000, got);
        u_m.stop();
        wait_sys(10);
        check(asleep, 1'b0);
        cmd(snv_pkg::OPC_SLEEP, 1'b0);
        wait_sys(4);
        check(asleep, 1'b1);
        u_m.pulses(4);
        wait_sys(1);
        check(asleep, 1'b1);
        check(so_oe_n, 1'b1);
        u_m.start(1'b0);
        wait_sys(10);
        check(asleep, 1'b0);
        u_m.bits(8, {24'h00_0000, snv_pkg::OPC_SET_WRITE_LATCH}, got);
        u_m.stop();
        wait_sys(8);
        check(write_latch_on, 1'b1);
        // second reset in mid-run must drop the latch that the last frame set
        reset = 1'b1;
        fork
            u_m.pulses(4);
            wait_sys(20);
        join
        reset = 1'b0;
        u_m.pulses(2);
        wel = 1'b0;
        wait_sys(4);
        check(write_latch_on, 1'b0);
        check(asleep, 1'b0);
        results();
    end
endmodule : testbench
